/* atp_consts.svh */
/*
  constants for the pattern and soft reset register block: register
  addresses, field positions, reset values and widths.
  assumes inclusion by bare name from the design files.
*/
`ifndef ATP_CONSTS_SVH
`define ATP_CONSTS_SVH

`define ATP_ADDR_RESET 8'h00
`define ATP_ADDR_FORMAT 8'h01
`define ATP_ADDR_OUTMODE 8'h02
`define ATP_ADDR_PAT_HIGH 8'h03
`define ATP_ADDR_PAT_LOW 8'h04
`define ATP_RESET_BIT 7
`define ATP_PAT_EN_BIT 7
`define ATP_PAT_HIGH_MSB 5
`define ATP_REG_RESET_VAL 8'h00
`define ATP_SLEEP_CYCLES 4'h4
`define ATP_WORD_BITS 16
`define ATP_NUM_CHAN 4

`endif

/* atp_pkg.sv */
/*
  types shared by the pattern and soft reset block.
  assumes the constants header is available.
*/
package atp_pkg;
  typedef logic [7:0] atp_byte_t;
  typedef logic [13:0] atp_sample_t;
  typedef enum logic [1:0] {
    ATP_SH_IDLE,
    ATP_SH_ADDR,
    ATP_SH_DATA
  } atp_shift_e;
endpackage : atp_pkg

/* atp_serial_rx.sv */
/*
  serial write receiver: takes the three port pins, already synchronised
  to sys_clk, and emits one write strobe per complete 16-bit write frame.
  assumes frames of rw bit, 7 address bits, 8 data bits, msb first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "atp_consts.svh"

module atp_serial_rx (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdi,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [15:0] sh_reg, sh_next;
  logic [4:0] cnt_reg, cnt_next;
  logic sck_d_reg;
  logic stb_reg, stb_next;
  logic [7:0] addr_reg, addr_next, data_reg, data_next;

  always_comb begin
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    stb_next = 1'b0;
    addr_next = addr_reg;
    data_next = data_reg;
    if (sel_n) begin
      cnt_next = 5'h00;
    end else if (sck && !sck_d_reg) begin
      sh_next = {sh_reg[14:0], sdi};
      cnt_next = cnt_reg + 5'h01;
      // write frames only: the rw bit is low
      if (cnt_reg == 5'h0f && !sh_reg[14]) begin
        stb_next = 1'b1;
        addr_next = {1'b0, sh_reg[13:7]};
        data_next = {sh_reg[6:0], sdi};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sh_reg <= 16'h0000;
      cnt_reg <= 5'h00;
      sck_d_reg <= 1'b0;
      stb_reg <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      sck_d_reg <= sck;
      stb_reg <= stb_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  assign wr_stb = stb_reg;
  assign wr_addr = addr_reg;
  assign wr_data = data_reg;
endmodule : atp_serial_rx

`default_nettype wire

/* atp_pattern_regs.sv */
/*
  mode control registers of the quad converter: soft reset, format,
  output mode, test pattern high and low, and pattern substitution.
  assumes the port pins come from another domain and the host writes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "atp_consts.svh"

module atp_pattern_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_sel_n,
  input wire logic cfg_sck,
  input wire logic cfg_sdi,
  input wire logic [55:0] conv_data,
  output logic [55:0] chan_out,
  output logic [7:0] format_bits,
  output logic [7:0] outmode_bits,
  output logic pattern_output_enable,
  output logic sleep_force,
  output logic soft_reset_busy
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sync1_reg, sync2_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // idle pin levels: no false sck edge right after reset
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
    end else begin
      sync1_reg <= {cfg_sel_n, cfg_sck, cfg_sdi};
      sync2_reg <= sync1_reg;
    end
  end

  logic wr_stb;
  logic [7:0] wr_addr, wr_data;
  atp_serial_rx u_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel_n(sync2_reg[2]),
    .sck(sync2_reg[1]),
    .sdi(sync2_reg[0]),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // ************************************************************
  // register file
  // ************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  atp_pkg::atp_byte_t fmt_reg, fmt_next, om_reg, om_next;
  atp_pkg::atp_byte_t ph_reg, ph_next, pl_reg, pl_next;
  logic [3:0] slp_reg, slp_next;
  logic soft_rst;

  // only bit 7 matters; other written bits are dropped
  assign soft_rst = wr_stb && hit(wr_addr, `ATP_ADDR_RESET)
    && wr_data[`ATP_RESET_BIT];

  always_comb begin
    fmt_next = fmt_reg;
    om_next = om_reg;
    ph_next = ph_reg;
    pl_next = pl_reg;
    slp_next = (slp_reg != 4'h0) ? slp_reg - 4'h1 : 4'h0;
    if (soft_rst) begin
      // reset bit is never stored, so no later write is needed to clear it
      fmt_next = `ATP_REG_RESET_VAL;
      om_next = `ATP_REG_RESET_VAL;
      ph_next = `ATP_REG_RESET_VAL;
      pl_next = `ATP_REG_RESET_VAL;
      slp_next = `ATP_SLEEP_CYCLES;
    end else if (wr_stb) begin
      if (hit(wr_addr, `ATP_ADDR_FORMAT)) begin
        fmt_next = wr_data;
      end
      if (hit(wr_addr, `ATP_ADDR_OUTMODE)) begin
        om_next = wr_data;
      end
      if (hit(wr_addr, `ATP_ADDR_PAT_HIGH)) begin
        ph_next = wr_data;
      end
      if (hit(wr_addr, `ATP_ADDR_PAT_LOW)) begin
        pl_next = wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fmt_reg <= `ATP_REG_RESET_VAL;
      om_reg <= `ATP_REG_RESET_VAL;
      ph_reg <= `ATP_REG_RESET_VAL;
      pl_reg <= `ATP_REG_RESET_VAL;
      slp_reg <= 4'h0;
    end else begin
      fmt_reg <= fmt_next;
      om_reg <= om_next;
      ph_reg <= ph_next;
      pl_reg <= pl_next;
      slp_reg <= slp_next;
    end
  end

  // ************************************************************
  // output substitution
  // ************************************************************
  atp_pkg::atp_sample_t pattern;
  assign pattern = {ph_reg[`ATP_PAT_HIGH_MSB:0], pl_reg};

  logic [55:0] out_reg, out_next;
  genvar g;
  generate
    for (g = 0; g < `ATP_NUM_CHAN; g = g + 1) begin : g_chan
      always_comb begin
        out_next[g*14 +: 14] = ph_reg[`ATP_PAT_EN_BIT] ? pattern
          : conv_data[g*14 +: 14];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_reg <= 56'h0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign chan_out = out_reg;
  assign format_bits = fmt_reg;
  assign outmode_bits = om_reg;
  assign pattern_output_enable = ph_reg[`ATP_PAT_EN_BIT];
  // sleep held a few cycles after a soft reset so converter restarts cleanly
  assign sleep_force = (slp_reg != 4'h0);
  assign soft_reset_busy = (slp_reg != 4'h0);
endmodule : atp_pattern_regs

`default_nettype wire

/* atp_chk_asserts.sv */
/* checker for atp_pattern_regs ports; bound below, one clock */
`timescale 1ns/100ps
`default_nettype none
module atp_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_sel_n,
  input wire logic [55:0] conv_data,
  input wire logic [55:0] chan_out,
  input wire logic [7:0] format_bits,
  input wire logic [7:0] outmode_bits,
  input wire logic pattern_output_enable,
  input wire logic sleep_force,
  input wire logic soft_reset_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_nap;
    sleep_force[*4] ##1 !sleep_force;
  endsequence
  // port quiet long enough for any frame to have landed
  sequence s_idle;
    cfg_sel_n[*8];
  endsequence
  a_busy_tracks: assert property (soft_reset_busy == sleep_force)
    else $error("busy differs from sleep");
  a_nap_len: assert property ($rose(sleep_force) |-> s_nap)
    else $error("sleep pulse length wrong");
  a_nap_clears: assert property ($rose(sleep_force) |->
    format_bits == 8'h00 && outmode_bits == 8'h00 && !pattern_output_enable)
    else $error("registers not cleared");
  a_pass_thru: assert property (!pattern_output_enable |=>
    chan_out == $past(conv_data))
    else $error("normal data not passed");
  a_pat_copy: assert property (pattern_output_enable |=>
    chan_out[13:0] == chan_out[27:14] && chan_out[27:14] == chan_out[41:28]
    && chan_out[41:28] == chan_out[55:42])
    else $error("channels differ under pattern");
  a_pat_hold: assert property (s_idle ##0 pattern_output_enable &&
    $past(pattern_output_enable) |=> $stable(chan_out[13:0]))
    else $error("pattern drifts");
  a_sleep_once: assert property ($fell(sleep_force) |->
    !sleep_force[*8])
    else $error("reset retriggered");
  a_mode_hold: assert property (s_idle |=> $stable(format_bits) &&
    $stable(outmode_bits) && $stable(pattern_output_enable))
    else $error("mode changed without write");
endmodule : atp_chk
bind atp_pattern_regs atp_chk i_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .cfg_sel_n(cfg_sel_n),
  .conv_data(conv_data),
  .chan_out(chan_out),
  .format_bits(format_bits),
  .outmode_bits(outmode_bits),
  .pattern_output_enable(pattern_output_enable),
  .sleep_force(sleep_force),
  .soft_reset_busy(soft_reset_busy)
);
`default_nettype wire

/* atp_host.sv */
/* host model on the serial port; needs the bench clock */
`timescale 1ns/100ps
`default_nettype none
module atp_host (
  input wire logic sys_clk,
  output logic sel_n,
  output logic sck,
  output logic sdi
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // whole frame msb first; sck idles low, halves of 4 clocks
  task send(input logic [15:0] f);
    @(negedge sys_clk);
    // select idles high, so one toggle opens the frame
    sel_n = ~sel_n;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      repeat (4) @(negedge sys_clk);
      sck = ~sck;
      repeat (4) @(negedge sys_clk);
      sck = ~sck;
    end
    sel_n = ~sel_n;
    sdi = ~sdi; // released line shows no stale bit
    repeat (12) @(negedge sys_clk);
  endtask : send
endmodule : atp_host
`default_nettype wire

/* tb.sv */
/* bench for atp_pattern_regs; host model drives the serial pins */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk, rst_n, sel_n, sck, sdi, pen, slp, busy;
  logic [55:0] conv_data, chan_out, naps, base, cd;
  logic [7:0] fmt, omode;
  int errors, compares;
  wire [55:0] st = {38'h0, fmt, omode, pen, busy};
  atp_pattern_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .cfg_sel_n(sel_n), .cfg_sck(sck), .cfg_sdi(sdi), .conv_data(conv_data),
    .chan_out(chan_out), .format_bits(fmt), .outmode_bits(omode),
    .pattern_output_enable(pen), .sleep_force(slp), .soft_reset_busy(busy));
  atp_host i_host (.sys_clk(sys_clk), .sel_n(sel_n), .sck(sck), .sdi(sdi));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (!rst_n) naps <= 56'h0;
    else if (slp === 1'b1) naps <= naps + 56'h1;
  end
  // converter words move every cycle so pass-through is seen on live data
  always @(negedge sys_clk) begin
    if (!rst_n) conv_data <= 56'h0123456789abcd;
    else conv_data <= conv_data + 56'h01040c1c3c7cfd;
  end
  task chk(input logic [55:0] g, input logic [55:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task end_sim;
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task t_first;
    i_host.send(16'h0080);
    chk(naps, 56'h4);
    chk(st, 56'h0);
  endtask : t_first
  task t_pattern;
    i_host.send(16'h015a);
    i_host.send(16'h023c);
    i_host.send(16'h03ff);
    i_host.send(16'h04a5);
    chk(st, {38'h0, 16'h5a3c, 2'h2});
    chk(chan_out, {4{14'h3fa5}});
    @(negedge sys_clk);
    chk(chan_out, {4{14'h3fa5}});
  endtask : t_pattern
  task t_ignore;
    base = naps;
    i_host.send(16'h007f);
    i_host.send(16'h8400);
    chk(st, {38'h0, 16'h5a3c, 2'h2});
    chk(chan_out, {4{14'h3fa5}});
    chk(naps - base, 56'h0);
  endtask : t_ignore
  task t_clear;
    base = naps;
    i_host.send(16'h00ff);
    chk(naps - base, 56'h4);
    chk(st, 56'h0);
    // read before this edge's update: the word that chan_out now carries
    cd = conv_data;
    chk(chan_out, cd);
    @(negedge sys_clk);
    cd = conv_data;
    chk(chan_out, cd);
    base = naps;
    i_host.send(16'h0380);
    chk(chan_out, 56'h0);
    chk(naps - base, 56'h0);
  endtask : t_clear
  task t_hwreset;
    i_host.send(16'h03bf);
    chk(chan_out, {4{14'h3f00}});
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(st, 56'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    cd = conv_data;
    chk(chan_out, cd);
    base = naps;
    i_host.send(16'h0080);
    chk(naps - base, 56'h4);
    chk(st, 56'h0);
  endtask : t_hwreset
  initial begin
    repeat (9000) @(negedge sys_clk);
    errors++;
    $display("BAD %0t timeout", $time);
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_first();
    t_pattern();
    t_ignore();
    t_clear();
    t_hwreset();
    end_sim();
  end
endmodule : tb
`default_nettype wire
